// ==== hw/ddr3_mode_regs.svh ====
`ifndef DDR3_MODE_REGS_SVH
`define DDR3_MODE_REGS_SVH

// Mode register selection on the bank address pins during a mode register set.
`define BA_MR0 3'h0
`define BA_MR1 3'h1

// Mode register 0 field positions.
`define MR0_BL_LSB 0
`define MR0_BL_MSB 1
`define MR0_BT_BIT 3
`define MR0_DLLRST_BIT 8
`define MR0_WR_LSB 9
`define MR0_WR_MSB 11
`define MR0_PPD_BIT 12

// Mode register 1 field positions.
`define MR1_DLLDIS_BIT 0
`define MR1_RTT0_BIT 2
`define MR1_RTT1_BIT 6
`define MR1_WLVL_BIT 7
`define MR1_RTT2_BIT 9
`define MR1_QOFF_BIT 12

// Burst chop select pin sampled with reads and writes; low selects the chop.
`define BC_N_BIT 12

// Burst length codes.
`define BL_FIX8 2'h0
`define BL_OTF 2'h1
`define BL_FIX4 2'h2

// Reset values of the mode registers.
`define MR0_RST 16'h0000
`define MR1_RST 16'h0000

// Default precharge time in clock cycles.
`define TRP_CYC_DEF 4

`endif

// ==== hw/ddr3_mode_pkg.sv ====
package ddr3_mode_pkg;

  // Command pins as seen at one clock edge.
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [15:0] addr;
  } cmd_t;

  // Two data beats per clock: b0 on the rising edge, b1 on the falling edge.
  typedef struct packed {
    logic [15:0] b1;
    logic [15:0] b0;
  } beat_pair_t;

  // One column group of eight beats, index equals the low column bits.
  typedef logic [7:0][15:0] line_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RFETCH = 5'b00010,
    ST_RSEND = 5'b00100,
    ST_WRITE = 5'b01000,
    ST_WDONE = 5'b10000
  } burst_state_t;

endpackage : ddr3_mode_pkg

// ==== hw/ddr3_burst_order.sv ====
// Behaviour
// RQ1 - A3 selects sequential or interleaved order.
// RQ2 - A1:A0 select chop, full burst or on-the-fly.
// RQ3 - On the fly, A12 picks chop per command.
// RQ4 - Sequential: wrap low bits, then other group.
// RQ5 - Interleaved: beat i from start XOR i.
// RQ6 - Chopped read: four beats, then drivers off.
// RQ7 - Chopped write: CA2 group, ascending, tail dropped.
// RQ8 - Full write ignores CA, stores ascending.
// RQ9 - Fixed chop write starts two clocks earlier.
// RQ10 - On-the-fly chop write starts like full burst.
// RQ11 - DLL reset bit clears itself after use.
// RQ12 - Controller waits DLL lock after DLL reset.
// RQ13 - Controller follows DLL enable with DLL reset.
// RQ14 - Write recovery plus precharge gives auto-precharge delay.
// RQ15 - A12 low freezes DLL in precharge power-down.
// RQ16 - A12 high keeps DLL running in power-down.
// RQ17 - All strobes low, BA 001 loads register 1.
// RQ18 - Write leveling limits termination unless outputs off.
// RQ19 - Termination during writes only RZQ/2,4,6.
// RQ20 - DLL off in self-refresh, back on exit.
// RQ21 - Clock enable high throughout DLL lock.
// RQ22 - DLL-off mode needs nominal termination disabled.
// RQ23 - DLL-off mode needs write termination disabled.
// RQ24 - All strobes low, BA 000 loads register 0.
// RQ25 - Burst code 00 full, 01 on-the-fly, 10 chop.
`timescale 1ns/1ns
`default_nettype none
`include "ddr3_mode_regs.svh"

// Write beat buffer between the pins and the line assembler.
module beat_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [WIDTH-1:0] s_data,
  output logic m_valid,
  input wire logic m_ready,
  output logic [WIDTH-1:0] m_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign s_ready = (count_q != CW'(DEPTH));
  assign m_valid = (count_q != '0);
  assign m_data = mem_q[rd_ptr_q];
  assign push = s_valid & s_ready;
  assign pop = m_valid & m_ready;

  // Storage is written only on an accepted push.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= s_data;
    end
  end

  // Pointers wrap explicitly so that depths other than powers of two work.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr_q + 1'b1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr_q + 1'b1);
      end
      if (push && !pop) begin
        count_q <= CW'(count_q + 1'b1);
      end else if (pop && !push) begin
        count_q <= CW'(count_q - 1'b1);
      end
    end
  end
endmodule : beat_fifo

module ddr3_burst_order import ddr3_mode_pkg::*; #(
  parameter int TRP_CYC = `TRP_CYC_DEF,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire cmd_t cmd,
  input wire beat_pair_t dq_pair_i,
  input wire logic dq_strobe_i,
  output beat_pair_t dq_pair_o,
  output logic dq_oe_n,
  output logic dqs_oe_n,
  output logic wfifo_ready,
  output logic rd_req,
  input wire line_t rd_line,
  input wire logic rd_line_valid,
  output line_t wr_line,
  output logic [7:0] wr_mask,
  output logic wr_valid,
  input wire logic wr_accept,
  input wire logic ppd_active,
  input wire logic sr_active,
  output logic dll_reset_pulse,
  output logic dll_on,
  output logic dll_frozen,
  output logic [1:0] bl_mode,
  output logic burst_interleave,
  output logic [2:0] wr_recovery,
  output logic [7:0] dal_cycles,
  output logic write_level,
  output logic qoff,
  output logic [2:0] rtt_nom
);
  cmd_t cmd_s1_q;
  cmd_t cmd_s2_q;
  beat_pair_t dq_s1_q;
  beat_pair_t dq_s2_q;
  logic strobe_s1_q;
  logic strobe_s2_q;
  logic [15:0] mr0_q;
  logic [15:0] mr1_q;
  logic dll_on_q;
  logic dll_frozen_q;
  burst_state_t st_q;
  logic [2:0] col_q;
  logic chop_q;
  logic otf_q;
  logic ilv_q;
  logic [1:0] pair_q;
  logic rd_req_q;
  line_t line_q;
  beat_pair_t dq_out_q;
  logic oe_n_q;
  logic [15:0] wbeat_q [8];
  logic wmask_q [8];
  logic [15:0] rd_beat [2];
  logic act;
  logic mrs;
  logic rd_cmd;
  logic wr_cmd;
  logic cmd_chop;
  logic fifo_valid;
  logic pop;
  logic keep_pair;
  logic last_pair;
  logic [2:0] wt0;
  beat_pair_t fifo_pair;

  // Column index of beat i for a burst starting at column start.
  function automatic logic [2:0] beat_col(input logic [2:0] start, input logic [2:0] i, input logic ilv);
    if (ilv) begin
      return start ^ i;
    end
    return {start[2] ^ i[2], 2'(start[1:0] + i[1:0])};
  endfunction : beat_col

  // Pins come from the controller's clock tree, so two stages before any decode.
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_s1_q <= '1;
      cmd_s2_q <= '1;
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      strobe_s1_q <= 1'b0;
      strobe_s2_q <= 1'b0;
    end else begin
      cmd_s1_q <= cmd;
      cmd_s2_q <= cmd_s1_q;
      dq_s1_q <= dq_pair_i;
      dq_s2_q <= dq_s1_q;
      strobe_s1_q <= dq_strobe_i;
      strobe_s2_q <= strobe_s1_q;
    end
  end

  // Command decode from the strobe pins.
  assign act = !cmd_s2_q.cs_n;
  assign mrs = act & !cmd_s2_q.ras_n & !cmd_s2_q.cas_n & !cmd_s2_q.we_n;
  assign rd_cmd = act & cmd_s2_q.ras_n & !cmd_s2_q.cas_n & cmd_s2_q.we_n;
  assign wr_cmd = act & cmd_s2_q.ras_n & !cmd_s2_q.cas_n & !cmd_s2_q.we_n;

  // Chop is fixed by the mode or, on the fly, taken from the pin at the command.
  always_comb begin
    case (mr0_q[`MR0_BL_MSB:`MR0_BL_LSB]) // RQ2 RQ25
      `BL_FIX4: cmd_chop = 1'b1;
      `BL_OTF: cmd_chop = !cmd_s2_q.addr[`BC_N_BIT]; // RQ3
      default: cmd_chop = 1'b0;
    endcase
  end

  // Mode register 0 load; the DLL reset bit drops one cycle after it is seen.
  always_ff @(posedge clk) begin
    if (rst) begin
      mr0_q <= `MR0_RST;
    end else if (mrs && cmd_s2_q.ba == `BA_MR0) begin // RQ24
      mr0_q <= cmd_s2_q.addr;
    end else if (mr0_q[`MR0_DLLRST_BIT]) begin
      mr0_q[`MR0_DLLRST_BIT] <= 1'b0; // RQ11
    end
  end

  // Mode register 1 load.
  always_ff @(posedge clk) begin
    if (rst) begin
      mr1_q <= `MR1_RST;
    end else if (mrs && cmd_s2_q.ba == `BA_MR1) begin // RQ17
      mr1_q <= cmd_s2_q.addr;
    end
  end

  // DLL runs when enabled and the part is out of self-refresh; slow exit freezes it.
  always_ff @(posedge clk) begin
    if (rst) begin
      dll_on_q <= 1'b0;
      dll_frozen_q <= 1'b0;
    end else begin
      dll_on_q <= !mr1_q[`MR1_DLLDIS_BIT] && !sr_active; // RQ20
      dll_frozen_q <= ppd_active && !mr0_q[`MR0_PPD_BIT]; // RQ15 RQ16
    end
  end

  // Mode fields presented to the rest of the device.
  assign dll_reset_pulse = mr0_q[`MR0_DLLRST_BIT];
  assign dll_on = dll_on_q;
  assign dll_frozen = dll_frozen_q;
  assign bl_mode = mr0_q[`MR0_BL_MSB:`MR0_BL_LSB];
  assign burst_interleave = mr0_q[`MR0_BT_BIT];
  assign wr_recovery = mr0_q[`MR0_WR_MSB:`MR0_WR_LSB];
  assign dal_cycles = 8'(mr0_q[`MR0_WR_MSB:`MR0_WR_LSB]) + 8'(TRP_CYC); // RQ14
  assign write_level = mr1_q[`MR1_WLVL_BIT];
  assign qoff = mr1_q[`MR1_QOFF_BIT];
  assign rtt_nom = {mr1_q[`MR1_RTT2_BIT], mr1_q[`MR1_RTT1_BIT], mr1_q[`MR1_RTT0_BIT]};

  // Write beats queue here so the assembler may stall while the array is busy.
  beat_fifo #(
    .WIDTH($bits(beat_pair_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_wfifo (
    .clk(clk),
    .rst(rst),
    .s_valid(strobe_s2_q),
    .s_ready(wfifo_ready),
    .s_data(dq_s2_q),
    .m_valid(fifo_valid),
    .m_ready(st_q == ST_WRITE),
    .m_data(fifo_pair)
  );

  // A fixed chop ends after two clocks of data, everything else after four.
  assign pop = fifo_valid && st_q == ST_WRITE;
  assign last_pair = (chop_q && !otf_q) ? (pair_q == 2'h1) : (pair_q == 2'h3); // RQ9 RQ10
  assign keep_pair = !chop_q || !pair_q[1]; // RQ7

  // Burst sequencer; commands that arrive while a burst runs are ignored.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      pair_q <= 2'h0;
      col_q <= 3'h0;
      chop_q <= 1'b0;
      otf_q <= 1'b0;
      ilv_q <= 1'b0;
      rd_req_q <= 1'b0;
    end else begin
      rd_req_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          pair_q <= 2'h0;
          col_q <= cmd_s2_q.addr[2:0];
          chop_q <= cmd_chop;
          otf_q <= (mr0_q[`MR0_BL_MSB:`MR0_BL_LSB] == `BL_OTF);
          ilv_q <= mr0_q[`MR0_BT_BIT]; // RQ1
          if (rd_cmd) begin
            rd_req_q <= 1'b1;
            st_q <= ST_RFETCH;
          end else if (wr_cmd) begin
            st_q <= ST_WRITE;
          end
        end
        ST_RFETCH: begin
          if (rd_line_valid) begin
            st_q <= ST_RSEND;
          end
        end
        ST_RSEND: begin
          pair_q <= 2'(pair_q + 1'b1);
          if (pair_q == 2'h3) begin
            st_q <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (pop) begin
            pair_q <= 2'(pair_q + 1'b1);
            if (last_pair) begin
              st_q <= ST_WDONE;
            end
          end
        end
        ST_WDONE: begin
          if (wr_accept) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Read line is held for the whole burst.
  always_ff @(posedge clk) begin
    if (rst) begin
      line_q <= '0;
    end else if (st_q == ST_RFETCH && rd_line_valid) begin
      line_q <= rd_line;
    end
  end

  // Beat selection per half clock.
  for (genvar k = 0; k < 2; k++) begin : g_rd
    assign rd_beat[k] = line_q[beat_col(col_q, {pair_q, 1'(k)}, ilv_q)]; // RQ4 RQ5
  end

  // Output drivers; the tail of a chop and output disable leave the pins floating.
  always_ff @(posedge clk) begin
    if (rst) begin
      dq_out_q <= '0;
      oe_n_q <= 1'b1;
    end else if (st_q == ST_RSEND) begin
      dq_out_q <= {rd_beat[1], rd_beat[0]};
      oe_n_q <= (chop_q && pair_q[1]) || qoff; // RQ6
    end else begin
      oe_n_q <= 1'b1;
    end
  end

  assign dq_pair_o = dq_out_q;
  assign dq_oe_n = oe_n_q;
  assign dqs_oe_n = oe_n_q;
  assign rd_req = rd_req_q;
  assign wr_valid = (st_q == ST_WDONE);

  // Write targets ignore the low column bits; only CA2 moves a chop.
  assign wt0 = 3'({chop_q & col_q[2], 2'b00} + {pair_q, 1'b0}); // RQ7 RQ8

  // Each line entry captures its beat in ascending order.
  for (genvar j = 0; j < 8; j++) begin : g_wr
    always_ff @(posedge clk) begin
      if (rst) begin
        wbeat_q[j] <= 16'h0000;
        wmask_q[j] <= 1'b0;
      end else if (st_q == ST_IDLE && wr_cmd) begin
        wmask_q[j] <= 1'b0;
      end else if (pop && keep_pair && wt0 == 3'(j)) begin
        wbeat_q[j] <= fifo_pair.b0;
        wmask_q[j] <= 1'b1;
      end else if (pop && keep_pair && (wt0 | 3'h1) == 3'(j)) begin
        wbeat_q[j] <= fifo_pair.b1;
        wmask_q[j] <= 1'b1;
      end
    end
    assign wr_line[j] = wbeat_q[j];
    assign wr_mask[j] = wmask_q[j];
  end

  property p_bt_load;
    @(posedge clk) disable iff (rst)
    (mrs && cmd_s2_q.ba == `BA_MR0) |=> burst_interleave == $past(cmd_s2_q.addr[`MR0_BT_BIT]);
  endproperty
  a_bt_load: assert property (p_bt_load) else $error("burst type not loaded"); // RQ1

  property p_bl_load;
    @(posedge clk) disable iff (rst)
    (mrs && cmd_s2_q.ba == `BA_MR0) |=> bl_mode == $past(cmd_s2_q.addr[1:0]);
  endproperty
  a_bl_load: assert property (p_bl_load) else $error("burst length not loaded"); // RQ2

  property p_dllrst_clear;
    @(posedge clk) disable iff (rst)
    (dll_reset_pulse && !mrs) |=> !dll_reset_pulse;
  endproperty
  a_dllrst_clear: assert property (p_dllrst_clear) else $error("DLL reset bit stuck"); // RQ11

  property p_mr1_load;
    @(posedge clk) disable iff (rst)
    (mrs && cmd_s2_q.ba == `BA_MR1) |=> qoff == $past(cmd_s2_q.addr[`MR1_QOFF_BIT]);
  endproperty
  a_mr1_load: assert property (p_mr1_load) else $error("register 1 not loaded"); // RQ17

  property p_sr_dll;
    @(posedge clk) disable iff (rst)
    sr_active |=> !dll_on;
  endproperty
  a_sr_dll: assert property (p_sr_dll) else $error("DLL on in self-refresh"); // RQ20

  property p_ppd_freeze;
    @(posedge clk) disable iff (rst)
    (ppd_active && !mr0_q[`MR0_PPD_BIT]) |=> dll_frozen;
  endproperty
  a_ppd_freeze: assert property (p_ppd_freeze) else $error("DLL not frozen"); // RQ15

  property p_chop_float;
    @(posedge clk) disable iff (rst)
    (st_q == ST_RSEND && chop_q && pair_q == 2'h1 && !qoff) |=> !dq_oe_n ##1 dq_oe_n [*2];
  endproperty
  a_chop_float: assert property (p_chop_float) else $error("chop tail driven"); // RQ6

  property p_first_beat;
    @(posedge clk) disable iff (rst)
    (st_q == ST_RSEND && pair_q == 2'h0) |=> dq_pair_o.b0 == $past(line_q[col_q]);
  endproperty
  a_first_beat: assert property (p_first_beat) else $error("burst did not start at column"); // RQ4

  property p_fix_chop_early;
    @(posedge clk) disable iff (rst)
    (pop && pair_q == 2'h1 && chop_q && !otf_q) |=> st_q == ST_WDONE;
  endproperty
  a_fix_chop_early: assert property (p_fix_chop_early) else $error("fixed chop write late"); // RQ9

  property p_otf_chop_full;
    @(posedge clk) disable iff (rst)
    (pop && pair_q == 2'h1 && otf_q) |=> st_q == ST_WRITE;
  endproperty
  a_otf_chop_full: assert property (p_otf_chop_full) else $error("on-the-fly write early"); // RQ10

  property p_wr_ascend;
    @(posedge clk) disable iff (rst)
    (pop && pair_q == 2'h0 && !chop_q) |=> wr_line[0] == $past(fifo_pair.b0);
  endproperty
  a_wr_ascend: assert property (p_wr_ascend) else $error("full write not ascending"); // RQ8
endmodule : ddr3_burst_order
`default_nettype wire

// ==== bench/line_array_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Behavioural memory array behind the burst logic; lag sets how slowly it answers.
module line_array_model import ddr3_mode_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] lag,
  input wire logic rd_req,
  output line_t rd_line,
  output logic rd_line_valid,
  input wire logic wr_valid,
  output logic wr_accept
);
  logic rpend_q;
  logic [3:0] rcnt_q;
  logic [4:0] wcnt_q;
  line_t pat;

  // Column k holds C3 above its own index, so a wrong column shows at once.
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pat[k] = {8'hC3, 5'h00, 3'(k)};
    end
  end

  // Outside the valid cycle the line is inverted, so a late capture is never rescued by a stale value.
  assign rd_line = rd_line_valid ? pat : ~pat;

  // A fetch is answered after lag plus one idle cycles with a single valid cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      rpend_q <= 1'h0;
      rcnt_q <= 4'h0;
      rd_line_valid <= 1'h0;
    end else begin
      rd_line_valid <= 1'h0;
      if (rd_req) begin
        rpend_q <= 1'h1;
        rcnt_q <= lag;
      end else if (rpend_q && rcnt_q == 4'h0) begin
        rd_line_valid <= 1'h1;
        rpend_q <= 1'h0;
      end else if (rpend_q) begin
        rcnt_q <= rcnt_q - 4'h1;
      end
    end
  end

  // A finished line is taken after lag cycles of stall, with a one-cycle accept.
  always_ff @(posedge clk) begin
    if (rst) begin
      wcnt_q <= 5'h00;
      wr_accept <= 1'h0;
    end else if (wr_valid && !wr_accept) begin
      wr_accept <= (wcnt_q == {1'h0, lag});
      wcnt_q <= wcnt_q + 5'h01;
    end else begin
      wr_accept <= 1'h0;
      wcnt_q <= 5'h00;
    end
  end
endmodule : line_array_model
`default_nettype wire

// ==== bench/ddr3_burst_order_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module ddr3_burst_order_tb_top import ddr3_mode_pkg::*; ();
  localparam int TRP = 3;
  logic clk = 1'h0;
  logic rst = 1'h1;
  cmd_t cmd;
  beat_pair_t dq_pair_i, dq_pair_o;
  logic dq_strobe_i, dq_oe_n, dqs_oe_n, wfifo_ready, rd_req, rd_line_valid, wr_valid, wr_accept;
  logic ppd_active, sr_active, dll_reset_pulse, dll_on, dll_frozen, burst_interleave, write_level, qoff;
  line_t rd_line, wr_line;
  logic [7:0] wr_mask, dal_cycles;
  logic [1:0] bl_mode;
  logic [2:0] wr_recovery, rtt_nom;
  logic [3:0] lag;
  int errors = 0;
  int check_count = 0;
  int pulses, wcyc, t_full;

  ddr3_burst_order #(.TRP_CYC(TRP), .FIFO_DEPTH(8)) ddr3_burst_order_i (
    .clk(clk), .rst(rst), .cmd(cmd), .dq_pair_i(dq_pair_i), .dq_strobe_i(dq_strobe_i),
    .dq_pair_o(dq_pair_o), .dq_oe_n(dq_oe_n), .dqs_oe_n(dqs_oe_n), .wfifo_ready(wfifo_ready),
    .rd_req(rd_req), .rd_line(rd_line), .rd_line_valid(rd_line_valid), .wr_line(wr_line),
    .wr_mask(wr_mask), .wr_valid(wr_valid), .wr_accept(wr_accept), .ppd_active(ppd_active),
    .sr_active(sr_active), .dll_reset_pulse(dll_reset_pulse), .dll_on(dll_on), .dll_frozen(dll_frozen),
    .bl_mode(bl_mode), .burst_interleave(burst_interleave), .wr_recovery(wr_recovery),
    .dal_cycles(dal_cycles), .write_level(write_level), .qoff(qoff), .rtt_nom(rtt_nom));

  line_array_model line_array_model_i (
    .clk(clk), .rst(rst), .lag(lag), .rd_req(rd_req), .rd_line(rd_line),
    .rd_line_valid(rd_line_valid), .wr_valid(wr_valid), .wr_accept(wr_accept));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
      errors++;
    end
  endtask : chk

  // A wait that runs out of its bound ends the run at once.
  task automatic hang(input string name);
    $display("mismatch %s expected done seen timeout", name);
    errors++;
    end_of_test();
  endtask : hang

  // Commands are held for one cycle and then replaced by deselect.
  task automatic send(input logic [3:0] strobes, input logic [2:0] ba, input logic [15:0] addr);
    @(negedge clk);
    cmd = {strobes, ba, addr};
    @(negedge clk);
    cmd = {4'hF, 3'h0, 16'h0000};
  endtask : send

  // Mode register write; counts the cycles in which the DLL reset bit is seen set.
  task automatic mrs(input logic [2:0] ba, input logic [15:0] addr);
    send(4'h0, ba, addr);
    pulses = 0;
    repeat (6) begin
      @(negedge clk);
      if (dll_reset_pulse === 1'h1) begin
        pulses++;
      end
    end
  endtask : mrs

  // Beat pairs carry v0 upwards, b0 first.
  task automatic push(input logic [15:0] v0, input int n);
    for (int p = 0; p < n; p++) begin
      dq_strobe_i = 1'h1;
      dq_pair_i = {v0 + 16'(2 * p + 1), v0 + 16'(2 * p)};
      @(negedge clk);
    end
    dq_strobe_i = 1'h0;
  endtask : push

  // Read one burst and compare every driven beat with the column order worked out here.
  task automatic do_read(input logic [2:0] col, input logic a12, input logic il, input int npairs);
    logic [2:0] idx;
    int p;
    p = 0;
    send(4'h5, 3'h0, {3'h0, a12, 9'h000, col});
    repeat (30) begin
      @(negedge clk);
      if (dq_oe_n === 1'h0) begin
        for (int k = 0; k < 2; k++) begin
          idx = 3'(2 * p + k);
          idx = il ? (col ^ idx) : {col[2] ^ idx[2], col[1:0] + idx[1:0]};
          chk("read beat", {16'h0000, 8'hC3, 5'h00, idx}, k ? dq_pair_o.b1 : dq_pair_o.b0);
        end
        chk("strobe driver", 32'h0, dqs_oe_n);
        p++;
      end
    end
    chk("driven pairs", npairs, p);
  endtask : do_read

  // Write one burst; wcyc records how long the internal write took to become ready.
  task automatic do_write(input logic [15:0] addr, input int npairs, input logic [15:0] v0, input int nbeats,
                          input logic [2:0] base, input logic [7:0] mask);
    send(4'h4, 3'h0, addr);
    push(v0, npairs);
    wcyc = npairs;
    while (wr_valid !== 1'h1) begin
      if (wcyc > 30) begin
        hang("write line");
      end
      @(negedge clk);
      wcyc++;
    end
    chk("write mask", mask, wr_mask);
    for (int j = 0; j < nbeats; j++) begin
      chk("write beat", v0 + 16'(j), wr_line[base + 3'(j)]);
    end
    for (int j = 0; j < 20 && wr_valid === 1'h1; j++) begin
      @(negedge clk);
    end
    if (wr_valid !== 1'h0) begin
      hang("write accept");
    end
  endtask : do_write

  // Main sequence.
  initial begin
    cmd = {4'hF, 3'h0, 16'h0000};
    dq_pair_i = 32'h0000_0000;
    dq_strobe_i = 1'h0;
    ppd_active = 1'h0;
    sr_active = 1'h0;
    lag = 4'h0;
    repeat (4) @(negedge clk);
    rst = 1'h0;
    repeat (3) @(negedge clk);
    chk("burst mode", 32'h0, bl_mode);
    chk("read driver", 32'h1, dq_oe_n);
    chk("fifo ready", 32'h1, wfifo_ready);
    chk("dll on", 32'h1, dll_on);
    $display("test reset done");

    // DLL enable is followed by a DLL reset, as the controller must do.
    mrs(3'h1, 16'h0000);
    mrs(3'h0, 16'h1B09);
    chk("dll reset pulse", 32'h1, pulses);
    chk("burst mode", 32'h1, bl_mode);
    chk("burst order", 32'h1, burst_interleave);
    chk("write recovery", 32'h5, wr_recovery);
    chk("auto precharge", 32'(5 + TRP), dal_cycles);
    ppd_active = 1'h1;
    repeat (2) @(negedge clk);
    chk("dll frozen", 32'h0, dll_frozen);
    mrs(3'h0, 16'h0A00);
    chk("dll frozen", 32'h1, dll_frozen);
    chk("dll reset pulse", 32'h0, pulses);
    ppd_active = 1'h0;
    mrs(3'h1, 16'h1284);
    chk("burst mode", 32'h0, bl_mode);
    chk("dll on", 32'h1, dll_on);
    chk("termination", 32'h5, rtt_nom);
    chk("leveling", 32'h1, write_level);
    chk("outputs off", 32'h1, qoff);
    do_read(3'h2, 1'h1, 1'h0, 0);
    // DLL-off mode is entered with nominal termination cleared, then the write termination is cleared too.
    mrs(3'h1, 16'h0001);
    chk("dll on", 32'h0, dll_on);
    chk("termination", 32'h0, rtt_nom);
    mrs(3'h2, 16'h0003);
    chk("burst mode", 32'h0, bl_mode);
    mrs(3'h1, 16'h0000);
    chk("dll on", 32'h1, dll_on);
    sr_active = 1'h1;
    repeat (2) @(negedge clk);
    chk("dll on", 32'h0, dll_on);
    sr_active = 1'h0;
    repeat (2) @(negedge clk);
    chk("dll on", 32'h1, dll_on);
    // A fresh DLL reset is followed by a quiet lock period before any read.
    mrs(3'h0, 16'h0100);
    chk("dll reset pulse", 32'h1, pulses);
    repeat (16) @(negedge clk);
    $display("test mode registers done");

    // Every start column in both orders, then fixed and on-the-fly chop, with a slow array on one pass.
    for (int il = 0; il < 2; il++) begin
      lag = il ? 4'h5 : 4'h0;
      mrs(3'h0, {12'h000, 1'(il), 3'h0});
      for (int c = 0; c < 8; c++) begin
        do_read(3'(c), 1'h1, 1'(il), 4);
      end
      mrs(3'h0, {12'h000, 1'(il), 3'h2});
      do_read(3'h1, 1'h1, 1'(il), 2);
      do_read(3'h6, 1'h1, 1'(il), 2);
      mrs(3'h0, {12'h000, 1'(il), 3'h1});
      do_read(3'h5, 1'h0, 1'(il), 2);
      do_read(3'h3, 1'h1, 1'(il), 4);
    end
    $display("test reads done");

    // Write timing: fixed chop starts earlier, on-the-fly chop does not.
    lag = 4'h2;
    mrs(3'h0, 16'h0000);
    do_write(16'h0005, 4, 16'h7000, 8, 3'h0, 8'hFF);
    t_full = wcyc;
    mrs(3'h0, 16'h0002);
    do_write(16'h0007, 2, 16'h7100, 4, 3'h4, 8'hF0);
    chk("chop write start", 32'(t_full - 2), 32'(wcyc));
    mrs(3'h0, 16'h0001);
    do_write(16'h0003, 4, 16'h7200, 4, 3'h0, 8'h0F);
    chk("otf chop write start", 32'(t_full), 32'(wcyc));
    do_write(16'h1006, 4, 16'h7300, 8, 3'h0, 8'hFF);
    $display("test writes done");

    // Overfill the buffer while idle, then drain it through two writes against a stalling array.
    lag = 4'h6;
    mrs(3'h0, 16'h0000);
    push(16'h8000, 10);
    repeat (3) @(negedge clk);
    chk("fifo ready", 32'h0, wfifo_ready);
    do_write(16'h0000, 0, 16'h8000, 8, 3'h0, 8'hFF);
    do_write(16'h0000, 0, 16'h8008, 8, 3'h0, 8'hFF);
    repeat (2) @(negedge clk);
    chk("fifo ready", 32'h1, wfifo_ready);
    $display("test buffer done");
    end_of_test();
  end
endmodule : ddr3_burst_order_tb_top
`default_nettype wire
